// ===== alarm_pkg.sv
// constants for the alarm monitor and start-up sync control block
// assumes a 32-bit apb slave with word registers at index times four
package alarm_pkg;

    // =========================================================
    // bus and register geometry
    localparam int ADDR_W = 10;
    localparam int REG_W = 16;
    localparam int ALARM_W = 12;
    localparam logic [7:0] IDX_MAIN = 8'h00;
    localparam logic [7:0] IDX_SHUTOFF = 8'h02;
    localparam logic [7:0] IDX_STATUS = 8'h05;
    localparam logic [7:0] IDX_MASK = 8'h07;
    localparam logic [7:0] IDX_PLL = 8'h18;
    localparam logic [7:0] IDX_FUSE = 8'h1B;
    localparam logic [7:0] IDX_SYNC_AUX = 8'h1F;
    localparam logic [7:0] IDX_SYNC = 8'h20;

    // =========================================================
    // alarm status bit positions
    localparam int AL_ZERO = 0;
    localparam int AL_PLL = 1;
    localparam int AL_PATTERN = 2;
    localparam int AL_PAR_A = 3;
    localparam int AL_PAR_B = 4;
    localparam int AL_PAR_C = 5;
    localparam int AL_PAR_D = 6;
    localparam int AL_NEAR2 = 7;
    localparam int AL_NEAR1 = 8;
    localparam int AL_COLLIDE = 9;
    localparam int AL_DACCLK = 10;
    localparam int AL_DATACLK = 11;

    // =========================================================
    // control field positions
    localparam int MC_CLKDIV_SYNC_ENA = 2;
    localparam int MC_TX_ENABLE = 12;
    localparam int MC_DUAL_PARITY = 13;
    localparam int MC_PARITY_ENA = 14;
    localparam int MC_PATTERN_RUN = 15;
    localparam int SO_DACCLK = 0;
    localparam int SO_DATACLK = 1;
    localparam int SO_COLLIDE = 2;
    localparam int SO_W = 3;
    localparam int PLL_NDIVSYNC_BIT = 11;
    localparam int FUSE_SLEEP_BIT = 11;
    localparam int AUX_FIFO_SRC_LSB = 2;
    localparam int SS_IN_LSB = 12;
    localparam int SS_OUT_LSB = 8;
    localparam int SS_CLKDIV_BIT = 0;

    // =========================================================
    // reset values
    localparam logic [ALARM_W-1:0] MASK_RESET = 12'hFFF;
    localparam logic [3:0] SEL_OFF = 4'h0;

endpackage : alarm_pkg

// ===== alarm_sync_if.sv
// carries synchronised alarm levels, sync edge and tx pin level
// assumes both ends run on the one system clock
`timescale 1ns/1ps
interface alarm_sync_if;
    logic [alarm_pkg::ALARM_W-1:0] alarm_lvl;
    logic sync_rise;
    logic tx_pin;
    modport source (output alarm_lvl, output sync_rise, output tx_pin);
    modport sink (input alarm_lvl, input sync_rise, input tx_pin);
endinterface : alarm_sync_if

// ===== alarm_input_sync.sv
// two-flop synchronisers for alarm conditions, sync pin and tx pin
// assumes all inputs are asynchronous to mclk_in
`timescale 1ns/1ps
module alarm_input_sync (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [alarm_pkg::ALARM_W-1:0] alarm_cond_in,
    input wire logic sync_pin_in,
    input wire logic tx_enable_pin_in,
    alarm_sync_if.source ev
);
    localparam int W = alarm_pkg::ALARM_W;

    typedef struct packed {
        logic [W+1:0] stage1;
        logic [W+1:0] stage2;
        logic sync_last;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // =========================================================
    // synchroniser chain
    always_comb
    begin
        state_next = state_reg;
        state_next.stage1 = {tx_enable_pin_in, sync_pin_in, alarm_cond_in};
        state_next.stage2 = state_reg.stage1;
        state_next.sync_last = state_reg.stage2[W];
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // edge is taken after the second stage only
    assign ev.alarm_lvl = state_reg.stage2[W-1:0];
    assign ev.sync_rise = state_reg.stage2[W] & ~state_reg.sync_last;
    assign ev.tx_pin = state_reg.stage2[W+1];

endmodule : alarm_input_sync

// ===== alarm_monitor.sv
// alarm aggregation, output shut-off and start-up sync control
// assumes an apb master on mclk_in; alarm and sync pins are asynchronous
`timescale 1ns/1ps
module alarm_monitor (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [alarm_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    input wire logic [alarm_pkg::ALARM_W-1:0] alarm_cond_in,
    input wire logic sync_pin_in,
    input wire logic tx_enable_pin_in,
    output logic alarm_out,
    output logic dac_output_enable_out,
    output logic fuse_sleep_out,
    output logic [3:0] fifo_in_sync_sel_out,
    output logic [3:0] fifo_out_sync_sel_out,
    output logic [1:0] fifo_input_src_out,
    output logic clkdiv_sync_sel_out,
    output logic fifo_sync_pulse_out,
    output logic clkdiv_sync_pulse_out,
    output logic pll_ndiv_sync_pulse_out,
    output logic sync_done_out
);
    localparam int W = alarm_pkg::ALARM_W;
    localparam int RW = alarm_pkg::REG_W;

    typedef struct packed {
        logic [RW-1:0] main_ctl;
        logic [alarm_pkg::SO_W-1:0] shutoff;
        logic [W-1:0] status;
        logic [W-1:0] mask;
        logic pll_ndivsync;
        logic fuse_sleep;
        logic [1:0] fifo_src;
        logic [3:0] fifo_in_sel;
        logic [3:0] fifo_out_sel;
        logic clkdiv_sel;
        logic sync_done;
        logic fifo_pulse;
        logic clkdiv_pulse;
        logic pll_pulse;
        logic alarm;
        logic dac_on;
        logic [31:0] rdata;
    } state_type;

    localparam state_type RESET_STATE = '{
        mask: alarm_pkg::MASK_RESET,
        default: '0
    };

    alarm_sync_if ev ();

    state_type state_reg;
    state_type state_next;

    // =========================================================
    // helpers
    function automatic logic is_mapped(input logic [7:0] idx);
        case (idx)
            alarm_pkg::IDX_MAIN, alarm_pkg::IDX_SHUTOFF,
            alarm_pkg::IDX_STATUS, alarm_pkg::IDX_MASK,
            alarm_pkg::IDX_PLL, alarm_pkg::IDX_FUSE,
            alarm_pkg::IDX_SYNC_AUX, alarm_pkg::IDX_SYNC:
                is_mapped = 1'b1;
            default:
                is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // maps shut-off enables onto the alarm bits they watch
    function automatic logic [W-1:0] shut_vec(
        input logic [alarm_pkg::SO_W-1:0] so);
        shut_vec = '0;
        shut_vec[alarm_pkg::AL_DACCLK] = so[alarm_pkg::SO_DACCLK];
        shut_vec[alarm_pkg::AL_DATACLK] = so[alarm_pkg::SO_DATACLK];
        shut_vec[alarm_pkg::AL_COLLIDE] = so[alarm_pkg::SO_COLLIDE];
    endfunction : shut_vec

    // =========================================================
    // input synchronisers
    alarm_input_sync u_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .alarm_cond_in(alarm_cond_in),
        .sync_pin_in(sync_pin_in),
        .tx_enable_pin_in(tx_enable_pin_in),
        .ev(ev.source)
    );

    logic [7:0] idx;
    logic setup_phase;
    logic wr_access;
    logic [RW-1:0] wdata;
    logic [W-1:0] set_vec;
    logic forced_off;
    logic tx_req;
    logic status_wr;

    assign idx = paddr_in[alarm_pkg::ADDR_W-1:2];
    assign setup_phase = psel_in & ~penable_in;
    assign wr_access = psel_in & penable_in & pwrite_in & is_mapped(idx);
    assign wdata = pwdata_in[RW-1:0];
    assign status_wr = wr_access & (idx == alarm_pkg::IDX_STATUS);
    assign forced_off =
        |(state_reg.status & shut_vec(state_reg.shutoff));
    assign tx_req = ev.tx_pin | state_reg.main_ctl[alarm_pkg::MC_TX_ENABLE];

    // =========================================================
    // alarm qualification
    always_comb
    begin
        set_vec = ev.alarm_lvl;
        // zero check, fifo proximity and clock loss pass straight through
        set_vec[alarm_pkg::AL_PATTERN] = ev.alarm_lvl[alarm_pkg::AL_PATTERN]
            & state_reg.main_ctl[alarm_pkg::MC_PATTERN_RUN];
        set_vec[alarm_pkg::AL_PAR_A] = ev.alarm_lvl[alarm_pkg::AL_PAR_A]
            & state_reg.main_ctl[alarm_pkg::MC_PARITY_ENA];
        set_vec[alarm_pkg::AL_PAR_B] = ev.alarm_lvl[alarm_pkg::AL_PAR_B]
            & state_reg.main_ctl[alarm_pkg::MC_PARITY_ENA];
        set_vec[alarm_pkg::AL_PAR_C] = ev.alarm_lvl[alarm_pkg::AL_PAR_C]
            & state_reg.main_ctl[alarm_pkg::MC_PARITY_ENA]
            & state_reg.main_ctl[alarm_pkg::MC_DUAL_PARITY];
        set_vec[alarm_pkg::AL_PAR_D] = ev.alarm_lvl[alarm_pkg::AL_PAR_D]
            & state_reg.main_ctl[alarm_pkg::MC_PARITY_ENA]
            & state_reg.main_ctl[alarm_pkg::MC_DUAL_PARITY];
    end

    // =========================================================
    // next state
    always_comb
    begin
        state_next = state_reg;
        if (wr_access)
        begin
            case (idx)
                alarm_pkg::IDX_MAIN:
                    state_next.main_ctl = wdata;
                alarm_pkg::IDX_SHUTOFF:
                    state_next.shutoff = wdata[alarm_pkg::SO_W-1:0];
                alarm_pkg::IDX_MASK:
                    state_next.mask = wdata[W-1:0];
                alarm_pkg::IDX_PLL:
                    state_next.pll_ndivsync =
                        wdata[alarm_pkg::PLL_NDIVSYNC_BIT];
                alarm_pkg::IDX_FUSE:
                    state_next.fuse_sleep = wdata[alarm_pkg::FUSE_SLEEP_BIT];
                alarm_pkg::IDX_SYNC_AUX:
                    state_next.fifo_src =
                        wdata[alarm_pkg::AUX_FIFO_SRC_LSB +: 2];
                alarm_pkg::IDX_SYNC:
                begin
                    state_next.fifo_in_sel =
                        wdata[alarm_pkg::SS_IN_LSB +: 4];
                    state_next.fifo_out_sel =
                        wdata[alarm_pkg::SS_OUT_LSB +: 4];
                    state_next.clkdiv_sel =
                        wdata[alarm_pkg::SS_CLKDIV_BIT];
                end
                default:
                    state_next.main_ctl = state_reg.main_ctl;
            endcase
        end
        // writing zero clears a bit; a new event in the same cycle wins
        if (status_wr)
            state_next.status = (state_reg.status & wdata[W-1:0]) | set_vec;
        else
            state_next.status = state_reg.status | set_vec;
        // sync pulses follow the synchronised sync edge
        state_next.fifo_pulse = ev.sync_rise
            & ((state_reg.fifo_in_sel != alarm_pkg::SEL_OFF)
            | (state_reg.fifo_out_sel != alarm_pkg::SEL_OFF));
        // periodic edges are accepted the same way as a single one
        state_next.clkdiv_pulse = ev.sync_rise
            & state_reg.main_ctl[alarm_pkg::MC_CLKDIV_SYNC_ENA];
        state_next.pll_pulse = ev.sync_rise & state_reg.pll_ndivsync;
        // a shut-off alarm voids the sync so the host must resync
        state_next.sync_done = state_next.fifo_pulse
            | (state_reg.sync_done & ~forced_off);
        state_next.alarm = |(state_reg.status & ~state_reg.mask);
        state_next.dac_on =
            tx_req & state_reg.sync_done & ~forced_off;
        if (setup_phase)
        begin
            state_next.rdata = '0;
            case (idx)
                alarm_pkg::IDX_MAIN:
                    state_next.rdata[RW-1:0] = state_reg.main_ctl;
                alarm_pkg::IDX_SHUTOFF:
                    state_next.rdata[alarm_pkg::SO_W-1:0] = state_reg.shutoff;
                alarm_pkg::IDX_STATUS:
                    state_next.rdata[W-1:0] = state_reg.status;
                alarm_pkg::IDX_MASK:
                    state_next.rdata[W-1:0] = state_reg.mask;
                alarm_pkg::IDX_PLL:
                    state_next.rdata[alarm_pkg::PLL_NDIVSYNC_BIT] =
                        state_reg.pll_ndivsync;
                alarm_pkg::IDX_FUSE:
                    state_next.rdata[alarm_pkg::FUSE_SLEEP_BIT] =
                        state_reg.fuse_sleep;
                alarm_pkg::IDX_SYNC_AUX:
                    state_next.rdata[alarm_pkg::AUX_FIFO_SRC_LSB +: 2] =
                        state_reg.fifo_src;
                alarm_pkg::IDX_SYNC:
                begin
                    state_next.rdata[alarm_pkg::SS_IN_LSB +: 4] =
                        state_reg.fifo_in_sel;
                    state_next.rdata[alarm_pkg::SS_OUT_LSB +: 4] =
                        state_reg.fifo_out_sel;
                    state_next.rdata[alarm_pkg::SS_CLKDIV_BIT] =
                        state_reg.clkdiv_sel;
                end
                default:
                    state_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            state_reg <= RESET_STATE;
        else
            state_reg <= state_next;
    end

    // =========================================================
    // outputs
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~is_mapped(idx);
    assign prdata_out = state_reg.rdata;
    assign alarm_out = state_reg.alarm;
    assign dac_output_enable_out = state_reg.dac_on;
    assign fuse_sleep_out = state_reg.fuse_sleep;
    assign fifo_in_sync_sel_out = state_reg.fifo_in_sel;
    assign fifo_out_sync_sel_out = state_reg.fifo_out_sel;
    assign fifo_input_src_out = state_reg.fifo_src;
    assign clkdiv_sync_sel_out = state_reg.clkdiv_sel;
    assign fifo_sync_pulse_out = state_reg.fifo_pulse;
    assign clkdiv_sync_pulse_out = state_reg.clkdiv_pulse;
    assign pll_ndiv_sync_pulse_out = state_reg.pll_pulse;
    assign sync_done_out = state_reg.sync_done;

    // =========================================================
    // assertions
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    chk_alarm_pin_or: assert property (
        ##1 alarm_out == $past(|(state_reg.status & ~state_reg.mask)))
        else $error("alarm pin differs from unmasked status");

    chk_masked_quiet: assert property (
        ((state_reg.status & ~state_reg.mask) == '0) |=> !alarm_out)
        else $error("masked alarm reached the pin");

    chk_status_sticky: assert property (
        !status_wr |=> ((state_reg.status & $past(state_reg.status))
            == $past(state_reg.status)))
        else $error("status bit dropped without a clear");

    chk_pll_sets_flag: assert property (
        ev.alarm_lvl[alarm_pkg::AL_PLL] |=>
            state_reg.status[alarm_pkg::AL_PLL])
        else $error("pll unlock not recorded");

    chk_pattern_flag: assert property (
        (ev.alarm_lvl[alarm_pkg::AL_PATTERN]
            && state_reg.main_ctl[alarm_pkg::MC_PATTERN_RUN]) |=>
            state_reg.status[alarm_pkg::AL_PATTERN])
        else $error("pattern mismatch not recorded");

    chk_parity_c_dual: assert property (
        (!state_reg.main_ctl[alarm_pkg::MC_DUAL_PARITY]
            && !state_reg.status[alarm_pkg::AL_PAR_C]) |=>
            !state_reg.status[alarm_pkg::AL_PAR_C])
        else $error("word c parity set outside dual mode");

    chk_shutoff_forces: assert property (
        forced_off |=> !dac_output_enable_out [*2])
        else $error("shut-off alarm left outputs on");

    chk_tx_start: assert property (
        (tx_req && state_reg.sync_done && !forced_off) |=>
            dac_output_enable_out)
        else $error("transmit did not start after sync");

    chk_fifo_sync_stop: assert property (
        (state_reg.fifo_in_sel == alarm_pkg::SEL_OFF
            && state_reg.fifo_out_sel == alarm_pkg::SEL_OFF) |=>
            !fifo_sync_pulse_out)
        else $error("fifo synced with both selects off");

    chk_clkdiv_gate: assert property (
        !state_reg.main_ctl[alarm_pkg::MC_CLKDIV_SYNC_ENA] |=>
            !clkdiv_sync_pulse_out)
        else $error("clock divider synced while disabled");
    cov_alarm_raised: cover property (!alarm_out ##1 alarm_out);
    cov_shutoff_event: cover property (dac_output_enable_out ##1 forced_off);
    cov_sync_then_tx: cover property (
        fifo_sync_pulse_out ##[1:20] dac_output_enable_out);

endmodule : alarm_monitor

// ===== host_source_model.sv
// far-side model: data source that drives alarm levels, sync and tx pins
// assumes the bench drives requests on mclk_in; sync requests last one cycle, alarm and tx requests are held longer
`timescale 1ns/1ps
module host_source_model (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [alarm_pkg::ALARM_W-1:0] cond_req_in,
    input wire logic sync_req_in,
    input wire logic tx_req_in,
    output logic [alarm_pkg::ALARM_W-1:0] alarm_cond_out,
    output logic sync_pin_out,
    output logic tx_enable_pin_out
);
    int hold;
    // =========================================================
    // pin drivers
    // a sync request gives one rising edge held four cycles, never a train
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_enable_pin_out <= 1'b0;
            sync_pin_out <= 1'b0;
            alarm_cond_out <= '0;
            hold <= 0;
        end
        else
        begin
            tx_enable_pin_out <= tx_req_in;
            alarm_cond_out <= cond_req_in;
            if (sync_req_in && hold == 0)
                hold <= 4;
            else if (hold > 0)
                hold <= hold - 1;
            sync_pin_out <= (sync_req_in && hold == 0) || hold > 1;
        end
    end
endmodule : host_source_model

// ===== alarm_monitor_tb.sv
// self-checking bench for alarm_monitor against an integer model
// assumes host_source_model stands for the far-side data source
`timescale 1ns/1ps
module alarm_monitor_tb;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [alarm_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, r;
    logic pready, pslverr, e, alarm, dac_on, fuse_sleep, sel_clkdiv;
    logic fifo_p, clkdiv_p, pll_p, done, sync_req = 1'b0, tx_req = 1'b0;
    logic [alarm_pkg::ALARM_W-1:0] cond_req = '0;
    logic [alarm_pkg::ALARM_W-1:0] alarm_cond;
    logic sync_pin, tx_pin;
    logic [3:0] fin, fout;
    logic [1:0] fsrc;
    logic [2:0] seen;
    logic [31:0] v, w;
    int num_errors, n_tests, seed, stat, mask, main, i, k;

    alarm_monitor u_alarm_monitor (.mclk_in(mclk_in), .reset_in(reset_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr),
        .alarm_cond_in(alarm_cond), .sync_pin_in(sync_pin),
        .tx_enable_pin_in(tx_pin), .alarm_out(alarm),
        .dac_output_enable_out(dac_on), .fuse_sleep_out(fuse_sleep),
        .fifo_in_sync_sel_out(fin), .fifo_out_sync_sel_out(fout),
        .fifo_input_src_out(fsrc), .clkdiv_sync_sel_out(sel_clkdiv),
        .fifo_sync_pulse_out(fifo_p), .clkdiv_sync_pulse_out(clkdiv_p),
        .pll_ndiv_sync_pulse_out(pll_p), .sync_done_out(done));
    host_source_model u_host_source_model (.mclk_in(mclk_in),
        .reset_in(reset_in), .cond_req_in(cond_req), .sync_req_in(sync_req),
        .tx_req_in(tx_req), .alarm_cond_out(alarm_cond),
        .sync_pin_out(sync_pin), .tx_enable_pin_out(tx_pin));

    initial
    begin
        forever #10 mclk_in = ~mclk_in;
    end

    // =========================================================
    // checking and bus tasks
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic compare_word(input string what, input logic [31:0] exp,
                                input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : compare_word

    task automatic compare_pin(input string what, input logic exp,
                               input logic got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : compare_pin

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : tick

    // waits for pready however long it takes; only the watchdog cuts a hang
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk_in);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, idx, {16'h0000, d}, x, y);
    endtask : wr

    task automatic rd_check(input string what, input logic [7:0] idx,
                            input logic [31:0] exp);
        logic [31:0] x;
        logic y;
        apb(1'b0, idx, 32'h0000_0000, x, y);
        compare_word(what, exp, x);
    endtask : rd_check

    // =========================================================
    // reference model
    function automatic bit accepts(input int b);
        case (b)
            2: return main[15];
            3, 4: return main[14];
            5, 6: return main[14] && main[13];
            default: return 1'b1;
        endcase
    endfunction : accepts

    task automatic raise(input int b);
        cond_req <= 12'h001 << b;
        tick(6);
        cond_req <= '0;
        tick(4);
        if (accepts(b))
            stat = stat | (1 << b);
    endtask : raise

    task automatic do_sync;
        seen = 3'b000;
        sync_req <= 1'b1;
        @(posedge mclk_in);
        sync_req <= 1'b0;
        repeat (10)
        begin
            @(posedge mclk_in);
            seen = seen | {pll_p, clkdiv_p, fifo_p};
        end
    endtask : do_sync

    // =========================================================
    // scenarios
    initial
    begin
        num_errors = 0;
        n_tests = 0;
        stat = 0;
        seed = 32'hEDE1;
        tick(4);
        reset_in <= 1'b0;
        rd_check("mask reset", alarm_pkg::IDX_MASK, 32'h0000_0FFF);
        rd_check("status reset", alarm_pkg::IDX_STATUS, 32'h0);
        compare_pin("pready", 1'b1, pready);
        apb(1'b0, 8'h03, 32'h0, r, e);
        compare_word("unmapped read", 32'h0, r);
        compare_pin("unmapped error", 1'b1, e);
        wr(alarm_pkg::IDX_MASK, 16'h0000);
        for (k = 0; k < 2; k++)
        begin
            main = k ? 32'h4000 : 32'hE000;
            wr(alarm_pkg::IDX_MAIN, main[15:0]);
            for (i = 0; i < 12; i++)
            begin
                raise(i);
                rd_check("status", alarm_pkg::IDX_STATUS, stat);
                compare_pin("alarm pin", stat != 0, alarm);
                wr(alarm_pkg::IDX_STATUS, 16'h0000);
                stat = 0;
                tick(3);
                rd_check("cleared", alarm_pkg::IDX_STATUS, 32'h0);
                compare_pin("pin cleared", 1'b0, alarm);
            end
        end
        // random mask decides whether the collision reaches the pin
        mask = $random(seed) & 32'hFFF;
        wr(alarm_pkg::IDX_MASK, mask[15:0]);
        raise(alarm_pkg::AL_COLLIDE);
        rd_check("masked status", alarm_pkg::IDX_STATUS, stat);
        compare_pin("masked pin", !mask[9], alarm);
        wr(alarm_pkg::IDX_MASK, 16'h0000);
        tick(2);
        compare_pin("unmasked pin", 1'b1, alarm);
        wr(alarm_pkg::IDX_STATUS, 16'h0000);
        stat = 0;
        v = $random(seed) | 32'h1000;
        w = $random(seed);
        wr(alarm_pkg::IDX_SYNC, v[15:0]);
        wr(alarm_pkg::IDX_SYNC_AUX, w[15:0]);
        wr(alarm_pkg::IDX_MAIN, 16'h0004);
        wr(alarm_pkg::IDX_PLL, 16'h0800);
        tick(2);
        compare_word("in sel", v[15:12], fin);
        compare_word("out sel", v[11:8], fout);
        compare_word("input src", w[3:2], fsrc);
        compare_pin("clkdiv sel", v[0], sel_clkdiv);
        for (i = 0; i < 2; i++)
        begin
            do_sync;
            compare_word("sync pulses", 3'b111, seen);
        end
        compare_pin("sync done", 1'b1, done);
        wr(alarm_pkg::IDX_PLL, 16'h0000);
        wr(alarm_pkg::IDX_MAIN, 16'h0000);
        wr(alarm_pkg::IDX_SYNC, 16'h0000);
        do_sync;
        compare_word("quiet sync", 3'b000, seen);
        wr(alarm_pkg::IDX_MAIN, 16'h1000);
        tick(4);
        compare_pin("tx by bit", 1'b1, dac_on);
        wr(alarm_pkg::IDX_MAIN, 16'h0000);
        tx_req <= 1'b1;
        tick(6);
        compare_pin("tx by pin", 1'b1, dac_on);
        wr(alarm_pkg::IDX_SHUTOFF, 16'h0004);
        raise(alarm_pkg::AL_COLLIDE);
        compare_pin("forced off", 1'b0, dac_on);
        tx_req <= 1'b0;
        wr(alarm_pkg::IDX_FUSE, 16'h0800);
        tick(2);
        compare_pin("fuse sleep", 1'b1, fuse_sleep);
        rd_check("fuse reg", alarm_pkg::IDX_FUSE, 32'h0000_0800);
        conclude();
    end

    initial
    begin
        #(20 * 20000);
        num_errors++;
        conclude();
    end
endmodule : alarm_monitor_tb
